/* File: include/cpst_pkg.sv */
// Shared types and constants for the pipeline stage timing control
package cpst_pkg;

    localparam int unsigned CPST_REG_W         = 4;
    localparam int unsigned CPST_STAGES_FULL   = 5;
    localparam int unsigned CPST_STAGES_SHORT  = 4;
    localparam int unsigned CPST_ISSUE_CYCLES  = 1;
    localparam int unsigned CPST_CACHE_PREFETCH_HOLD     = 1;
    localparam logic [3:0]  CPST_REG_RESET     = 4'h0;

    // Instruction timing classes presented at decode
    typedef enum logic [3:0] {
        CPST_CLS_NOP        = 4'h0,
        CPST_CLS_DSP_UNARY  = 4'h1,
        CPST_CLS_DSP_ARITH  = 4'h2,
        CPST_CLS_DSP_LOGIC  = 4'h3,
        CPST_CLS_DSP_SHIFT  = 4'h4,
        CPST_CLS_DSP_MULT   = 4'h5,
        CPST_CLS_DSP_ACC    = 4'h6,
        CPST_CLS_REG_MOVE   = 4'h7,
        CPST_CLS_LOAD       = 4'h8,
        CPST_CLS_STORE      = 4'h9,
        CPST_CLS_PREDEC_ST  = 4'hA,
        CPST_CLS_PREFETCH   = 4'hB,
        CPST_CLS_XMEM_WORD  = 4'hC,
        CPST_CLS_SINGLE_LNG = 4'hD
    } cpst_class_e;

    // Decoded instruction as handed to the pipeline
    typedef struct packed {
        cpst_class_e             cls;
        logic [CPST_REG_W-1:0]   dst;
        logic [CPST_REG_W-1:0]   src_a;
        logic [CPST_REG_W-1:0]   src_b;
        logic                    use_a;
        logic                    use_b;
        logic                    cond;
    } cpst_instr_s;

    // One pipeline stage latch
    typedef struct packed {
        logic        valid;
        cpst_instr_s instr;
    } cpst_stage_s;

    // Whole state of the control block
    typedef struct packed {
        cpst_stage_s ex;
        cpst_stage_s ma;
        cpst_stage_s wb;
    } cpst_state_s;

    // Memory access stage request
    typedef struct packed {
        logic                  req;
        logic                  write;
        logic                  prefetch;
        logic [CPST_REG_W-1:0] reg_id;
    } cpst_mem_s;

    // Write-back port
    typedef struct packed {
        logic                  en;
        logic                  dsp;
        logic [CPST_REG_W-1:0] reg_id;
    } cpst_wb_s;

    function automatic logic cpst_is_dsp(input cpst_class_e c);
        return (c == CPST_CLS_DSP_UNARY) || (c == CPST_CLS_DSP_ARITH) ||
               (c == CPST_CLS_DSP_LOGIC) || (c == CPST_CLS_DSP_SHIFT) ||
               (c == CPST_CLS_DSP_MULT)  || (c == CPST_CLS_DSP_ACC);
    endfunction : cpst_is_dsp

    function automatic logic cpst_has_wb(input cpst_class_e c);
        return cpst_is_dsp(c) || (c == CPST_CLS_REG_MOVE) || (c == CPST_CLS_LOAD) ||
               (c == CPST_CLS_PREDEC_ST) || (c == CPST_CLS_XMEM_WORD) ||
               (c == CPST_CLS_SINGLE_LNG);
    endfunction : cpst_has_wb

    function automatic logic cpst_uses_bus(input cpst_class_e c);
        return (c == CPST_CLS_LOAD) || (c == CPST_CLS_STORE) ||
               (c == CPST_CLS_PREDEC_ST) || (c == CPST_CLS_PREFETCH);
    endfunction : cpst_uses_bus

endpackage : cpst_pkg

/* File: core/cpst_bus_arb.sv */
// Arbiter between instruction fetch and memory access on the shared bus
`timescale 1ns/1ps
module cpst_bus_arb
    import cpst_pkg::*;
(
    input  wire logic if_req,
    input  wire logic ma_req,
    output logic      if_gnt,
    output logic      ma_gnt,
    output logic      if_delayed
);

    // Memory access wins; the fetch slides to a later slot
    always_comb begin
        ma_gnt     = ma_req;
        if_gnt     = if_req && !ma_req;
        if_delayed = if_req && ma_req;
    end

endmodule : cpst_bus_arb

/* File: core/cpst_pipe_ctrl.sv */
// Pipeline stage sequencing, stalls and bus contention control
//
// Behaviour
// - DSP unary ops: one cycle, five stages
// - DSP carry/compare/abs/round: one cycle, five stages
// - DSP bitwise ops: one cycle, five stages
// - DSP shifts: one cycle, five stages
// - DSP signed multiply: one cycle, five stages
// - Accumulator moves stall X-word, single-long moves
// - Register moves: idle memory stage, write-back
// - Loads: five stages, write back loaded value
// - Stall dependent instruction right after load
// - Stores: four stages, no write-back
// - Pre-decrement store: access fourth, write fifth
// - Prefetch: four stages, no write-back
// - DSP variant holds decode after prefetch
// - Memory access arbitrated against instruction fetch
`timescale 1ns/1ps
module cpst_pipe_ctrl
    import cpst_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        dsp_variant,
    input  wire logic        id_valid,
    input  wire cpst_instr_s id_instr,
    output logic             id_ready,
    output logic             id_stall,
    input  wire logic        if_req,
    output logic             if_gnt,
    output logic             if_delayed,
    output logic             ex_valid,
    output cpst_class_e      ex_class,
    output cpst_mem_s        mem_req,
    output logic             ma_idle_hold,
    output cpst_wb_s         wb_port
);

    cpst_state_s state_r;
    cpst_state_s state_nxt;

    logic        load_use;
    logic        acc_conflict;
    logic        cache_prefetch_hold;
    logic        accept;
    logic        ma_bus;
    logic        ma_gnt;
    cpst_stage_s bubble;

    assign bubble = '0;

    // Hazard detection against the instruction now in execute
    always_comb begin
        load_use = 1'b0;
        acc_conflict = 1'b0;
        cache_prefetch_hold = 1'b0;
        if (state_r.ex.valid && id_valid) begin
            if (state_r.ex.instr.cls == CPST_CLS_LOAD) begin
                load_use = (id_instr.use_a && id_instr.src_a == state_r.ex.instr.dst) ||
                           (id_instr.use_b && id_instr.src_b == state_r.ex.instr.dst) ||
                           (cpst_has_wb(id_instr.cls) &&
                            id_instr.dst == state_r.ex.instr.dst);
            end
            if (state_r.ex.instr.cls == CPST_CLS_DSP_ACC) begin
                acc_conflict = (id_instr.cls == CPST_CLS_XMEM_WORD) ||
                               (id_instr.cls == CPST_CLS_SINGLE_LNG);
            end
            if (state_r.ex.instr.cls == CPST_CLS_PREFETCH) begin
                cache_prefetch_hold = dsp_variant;
            end
        end
    end

    assign id_stall = load_use || acc_conflict || cache_prefetch_hold;
    assign id_ready = !id_stall;
    assign accept   = id_valid && id_ready;

    // Stage advance: one instruction per slot, bubbles behind a stall
    always_comb begin
        state_nxt = state_r;
        if (accept) begin
            state_nxt.ex.valid = 1'b1;
            state_nxt.ex.instr = id_instr;
        end else begin
            state_nxt.ex = bubble;
        end
        state_nxt.ma = state_r.ex;
        if (state_r.ma.valid && cpst_has_wb(state_r.ma.instr.cls)) begin
            state_nxt.wb = state_r.ma;
        end else begin
            state_nxt.wb = bubble;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ma_bus = state_r.ma.valid && cpst_uses_bus(state_r.ma.instr.cls);

    cpst_bus_arb u_arb (
        .if_req     (if_req),
        .ma_req     (ma_bus),
        .if_gnt     (if_gnt),
        .ma_gnt     (ma_gnt),
        .if_delayed (if_delayed)
    );

    // Stage-facing outputs
    always_comb begin
        ex_valid = state_r.ex.valid;
        ex_class = state_r.ex.instr.cls;
        mem_req.req      = ma_gnt;
        mem_req.write    = ma_bus && ((state_r.ma.instr.cls == CPST_CLS_STORE) ||
                                      (state_r.ma.instr.cls == CPST_CLS_PREDEC_ST));
        mem_req.prefetch = ma_bus && (state_r.ma.instr.cls == CPST_CLS_PREFETCH);
        mem_req.reg_id   = state_r.ma.instr.dst;
        ma_idle_hold = state_r.ma.valid && !ma_bus;
        wb_port.en     = state_r.wb.valid;
        wb_port.dsp    = state_r.wb.valid && cpst_is_dsp(state_r.wb.instr.cls);
        wb_port.reg_id = state_r.wb.instr.dst;
    end

endmodule : cpst_pipe_ctrl

/* File: verification/cpst_pipe_checker.sv */
// Assertion checker for the pipeline stage timing control
`timescale 1ns/1ps
module cpst_pipe_checker
    import cpst_pkg::*;
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        dsp_variant,
    input wire logic        id_valid,
    input wire cpst_instr_s id_instr,
    input wire logic        id_ready,
    input wire logic        id_stall,
    input wire logic        if_req,
    input wire logic        if_gnt,
    input wire logic        if_delayed,
    input wire logic        ex_valid,
    input wire cpst_class_e ex_class,
    input wire cpst_mem_s   mem_req,
    input wire logic        ma_idle_hold,
    input wire cpst_wb_s    wb_port
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    AST_DSP_WB: assert property (ex_valid && ex_class inside {[CPST_CLS_DSP_UNARY:CPST_CLS_DSP_ACC]}
        |-> ##2 wb_port.en && wb_port.dsp) else $error("dsp op lacks write-back");
    AST_LOAD_WB: assert property (ex_valid && ex_class == CPST_CLS_LOAD
        |=> mem_req.req ##1 wb_port.en) else $error("load stage order wrong");
    AST_NO_WB: assert property (ex_valid && ex_class inside {CPST_CLS_STORE, CPST_CLS_PREFETCH}
        |=> mem_req.req ##1 !wb_port.en) else $error("store or prefetch wrote back");
    AST_PREDEC: assert property (ex_valid && ex_class == CPST_CLS_PREDEC_ST
        |=> mem_req.req ##1 wb_port.en) else $error("pre-decrement store order wrong");
    AST_IDLE_MA: assert property (ex_valid && ex_class == CPST_CLS_REG_MOVE
        |=> ma_idle_hold && !mem_req.req ##1 wb_port.en) else $error("move stage order wrong");
    AST_IF_LOSE: assert property (mem_req.req && if_req |-> !if_gnt && if_delayed)
        else $error("fetch not held off");
    AST_IF_WIN: assert property (!mem_req.req && if_req |-> if_gnt && !if_delayed)
        else $error("fetch refused needlessly");
    AST_CACHE_PREFETCH_HOLD: assert property (ex_valid && ex_class == CPST_CLS_PREFETCH && dsp_variant
        && id_valid |-> id_stall && !id_ready ##1 !ex_valid) else $error("prefetch hold missing");
    AST_TAKE: assert property (id_valid && id_ready |=> ex_valid && ex_class == $past(id_instr.cls))
        else $error("taken op not in execute");
    AST_STORE_KIND: assert property (ex_valid && ex_class inside {CPST_CLS_STORE, CPST_CLS_PREDEC_ST}
        |=> mem_req.write && !mem_req.prefetch) else $error("store not flagged as write");
    AST_CACHE_PREFETCH_KIND: assert property (ex_valid && ex_class == CPST_CLS_PREFETCH
        |=> mem_req.prefetch && !mem_req.write) else $error("prefetch not flagged");
    AST_LOAD_KIND: assert property (ex_valid && ex_class == CPST_CLS_LOAD
        |=> !mem_req.write && !mem_req.prefetch) else $error("load flagged as write");
    AST_MA_REG: assert property (id_valid && id_ready |=> ##1 mem_req.reg_id == $past(id_instr.dst, 2))
        else $error("memory stage register mismatch");
    AST_WB_REG: assert property (id_valid && id_ready && cpst_has_wb(id_instr.cls)
        |=> ##2 wb_port.en && wb_port.reg_id == $past(id_instr.dst, 3)) else $error("write-back register mismatch");
    AST_WB_PLAIN: assert property (ex_valid && ex_class inside {CPST_CLS_REG_MOVE, CPST_CLS_LOAD}
        |-> ##2 wb_port.en && !wb_port.dsp) else $error("plain write-back flagged as dsp");
    C_STALL: cover property (id_stall);
    C_LOST: cover property (mem_req.req && if_req);
    C_DSP: cover property (wb_port.en && wb_port.dsp);
endmodule : cpst_pipe_checker

bind cpst_pipe_ctrl cpst_pipe_checker i_chk (.clock, .arst_n, .dsp_variant, .id_valid, .id_instr,
    .id_ready, .id_stall, .if_req, .if_gnt, .if_delayed, .ex_valid, .ex_class, .mem_req,
    .ma_idle_hold, .wb_port);

/* File: verification/cpst_fetch_model.sv */
// Instruction fetch request model, prompt or every other slot
`timescale 1ns/1ps
module cpst_fetch_model (
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic slow,
    output logic      if_req
);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) if_req <= 1'b0;
        else if_req <= slow ? !if_req : 1'b1;
    end
endmodule : cpst_fetch_model

/* File: verification/cpst_pipe_ctrl_bench.sv */
// Self-checking bench for the pipeline stage timing control
`timescale 1ns/1ps
module cpst_pipe_ctrl_bench import cpst_pkg::*;;
    logic clock, arst_n, dsp_variant, slow, id_valid, id_ready, id_stall, if_req, if_gnt;
    logic if_delayed, ex_valid, ma_idle_hold;
    cpst_instr_s id_instr;
    cpst_class_e ex_class;
    cpst_mem_s   mem_req;
    cpst_wb_s    wb_port;
    int n_fail = 0, n_compared = 0, nwb = 0, nbus = 0, nlost = 0, w;
    cpst_pipe_ctrl i_cpst_pipe_ctrl (.clock, .arst_n, .dsp_variant, .id_valid, .id_instr,
        .id_ready, .id_stall, .if_req, .if_gnt, .if_delayed, .ex_valid, .ex_class, .mem_req,
        .ma_idle_hold, .wb_port);
    cpst_fetch_model i_cpst_fetch_model (.clock, .arst_n, .slow, .if_req);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (wb_port.en === 1'b1) nwb++;
        if (mem_req.req === 1'b1) nbus++;
        if (mem_req.req === 1'b1 && if_req === 1'b1 && if_gnt === 1'b0) nlost++;
    end
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic issue(input cpst_class_e c, input logic [3:0] d, s, input logic u);
        logic r;
        id_valid = 1'b1;
        id_instr = '{c, d, s, 4'h0, u, 1'b0, 1'b0};
        for (w = 0; w < 20; w++) begin
            #6 r = id_ready;
            @(posedge clock);
            #1;
            if (r === 1'b1) break;
        end
        if (w == 20) begin
            chk(w, 0);
            close_out();
        end
    endtask : issue
    task automatic idle(input int n);
        id_valid = 1'b0;
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : idle
    task automatic t_classes();
        {nwb, nbus, nlost} = '0;
        dsp_variant = 1'b1;
        for (int c = 1; c <= 13; c++) issue(cpst_class_e'(c), 4'(c), 4'h0, 1'b0);
        idle(6);
        chk(nwb, 11);
        chk(nbus, 4);
        chk(nlost, 4);
    endtask : t_classes
    task automatic t_hazards();
        slow = 1'b1;
        issue(CPST_CLS_LOAD, 4'h3, 4'h0, 1'b0);
        issue(CPST_CLS_DSP_ARITH, 4'h5, 4'h3, 1'b1);
        chk(w, 1);
        issue(CPST_CLS_LOAD, 4'h3, 4'h0, 1'b0);
        issue(CPST_CLS_DSP_LOGIC, 4'h5, 4'h4, 1'b1);
        chk(w, 0);
        issue(CPST_CLS_DSP_ACC, 4'h1, 4'h0, 1'b0);
        issue(CPST_CLS_XMEM_WORD, 4'h2, 4'h0, 1'b0);
        chk(w, 1);
        issue(CPST_CLS_PREFETCH, 4'h0, 4'h0, 1'b0);
        issue(CPST_CLS_NOP, 4'h0, 4'h0, 1'b0);
        chk(w, 1);
        idle(2);
        dsp_variant = 1'b0;
        issue(CPST_CLS_PREFETCH, 4'h0, 4'h0, 1'b0);
        issue(CPST_CLS_NOP, 4'h0, 4'h0, 1'b0);
        chk(w, 0);
        idle(4);
    endtask : t_hazards
    initial begin
        {arst_n, dsp_variant, slow, id_valid} = '0;
        id_instr = '0;
        repeat (16) @(posedge clock);
        #1 arst_n = 1'b1;
        idle(2);
        t_classes();
        t_hazards();
        close_out();
    end
endmodule : cpst_pipe_ctrl_bench
